// ===== rtl/rbv_map.vh
// Constants for the reset and boot vector selection block.
`ifndef RBV_MAP_VH
`define RBV_MAP_VH

// Boot marker and vectors.
`define RBV_SIG_PRESENT      8'hA5
`define RBV_RESET_VECTOR     16'h0000
`define RBV_SIG_BELOW_LOCK   16'h0001

// Reset cause bit positions.
`define RBV_CAUSE_POR        0
`define RBV_CAUSE_EXT        1
`define RBV_CAUSE_CMP        2
`define RBV_CAUSE_SW         3
`define RBV_CAUSE_SUPPLY     4
`define RBV_CAUSE_WDT        5
`define RBV_CAUSE_MCD        6
`define RBV_CAUSE_FLASH      7
`define RBV_CAUSE_W          8
`define RBV_CAUSE_RST        8'h01

// Synchronised input bit positions.
`define RBV_SYN_EXT          0
`define RBV_SYN_LOW          1
`define RBV_SYN_MON          2
`define RBV_SYN_CMP          3
`define RBV_SYN_MCD          4
`define RBV_SYN_W            5
`define RBV_SYN_RST          5'h1F

// Timing.
`define RBV_CLK_PERIOD_PS    25000
`define RBV_RST_HOLD_NS      1000
`define RBV_RST_HOLD_CYC     ((`RBV_RST_HOLD_NS * 1000 + `RBV_CLK_PERIOD_PS - 1) / `RBV_CLK_PERIOD_PS)
`define RBV_WDT_MAX_US       25000
// Scaled so the intermediate product stays inside 32-bit integer range.
`define RBV_WDT_MAX_CYC      ((`RBV_WDT_MAX_US * 1000) / (`RBV_CLK_PERIOD_PS / 1000))

`endif

// ===== rtl/rbv_sync.v
// Two-flop synchroniser bank for asynchronous reset request inputs.
`timescale 1ns/100ps
module rbv_sync #(
  parameter             WIDTH   = 5,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b1}}
) (
  input  wire             ref_clk_i,
  input  wire             rst_n_i,
  input  wire [WIDTH-1:0] async_i,
  output wire [WIDTH-1:0] sync_o
);

  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
      reg meta_r;
      reg sync_r;
      // Resetting to the asserted level keeps the core held until
      // real pin levels have propagated after power-up.
      always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          meta_r <= RST_VAL[g];
          sync_r <= RST_VAL[g];
        end else begin
          meta_r <= async_i[g];
          sync_r <= meta_r;
        end
      end
      assign sync_o[g] = sync_r;
    end
  endgenerate

endmodule // rbv_sync

// ===== rtl/rbv_reset_boot.v
// Reset gathering, core hold and boot vector selection.
`timescale 1ns/100ps
`include "rbv_map.vh"

// Operation
// - Hold reset while supply low, reset pin low, or an enabled source asks.
// - Sources: power-on, pin, comparator, software, monitor, watchdog, clock, flash.
// - In reset, stop execution and force registers and pins to defaults.
// - On release reload the program counter to 0x0000 unless bootloader flagged.
// - The marker byte sits at the address just below the lock byte.
// - Bootloader counts as present only when the marker equals 0xA5.
// - Any other marker value means the bootloader is absent.
// - Bootloader present: start at bootloader vector after every reset.
// - Bootloader absent: start at 0x0000 after every reset.
// - Bootloader vector lies in the final code flash page, which may be erased.
// - Watchdog overflow resets; after reset watchdog runs at maximum timeout.
module rbv_reset_boot #(
  parameter integer LOCK_ADDR   = 65535,
  parameter integer PAGE_BYTES  = 512,
  parameter integer WDT_MAX_CYC = `RBV_WDT_MAX_CYC,
  parameter integer WDT_W       = 20,
  parameter integer RST_HOLD    = `RBV_RST_HOLD_CYC
) (
  input  wire        ref_clk_i,
  input  wire        rst_n_i,
  input  wire        ext_rst_n_i,
  input  wire        supply_low_i,
  input  wire        vdd_mon_trip_i,
  input  wire        vdd_mon_en_i,
  input  wire        cmp_out_i,
  input  wire        cmp_rst_en_i,
  input  wire        mcd_fault_i,
  input  wire        mcd_en_i,
  input  wire        sw_rst_req_i,
  input  wire        flash_err_i,
  input  wire        wdt_kick_i,
  input  wire        wdt_disable_i,
  input  wire        wdt_lock_i,
  input  wire        flash_rd_valid_i,
  input  wire [7:0]  flash_rd_data_i,
  output reg         core_hold_o,
  output reg         fetch_en_o,
  output reg         pc_load_o,
  output reg  [15:0] pc_vector_o,
  output reg         flash_rd_o,
  output reg  [15:0] flash_addr_o,
  output reg         boot_present_o,
  output reg  [7:0]  rst_cause_o,
  output reg         wdt_running_o
);

  localparam [2:0] ST_HOLD    = 3'h0;
  localparam [2:0] ST_STRETCH = 3'h1;
  localparam [2:0] ST_SIG_RD  = 3'h2;
  localparam [2:0] ST_VECTOR  = 3'h3;
  localparam [2:0] ST_RUN     = 3'h4;

  // The bootloader occupies the page that holds the lock byte.
  localparam [31:0] BOOT_VEC32 = LOCK_ADDR & ~(PAGE_BYTES - 1);
  localparam [31:0] SIG_ADDR32 = LOCK_ADDR - 1;
  localparam [31:0] WDT_LAST32 = WDT_MAX_CYC - 1;
  localparam [31:0] HOLD_LAST32 = RST_HOLD - 1;
  localparam integer HOLD_W    = 8;

  wire [`RBV_SYN_W-1:0] syn_in;
  wire [`RBV_SYN_W-1:0] syn;

  assign syn_in[`RBV_SYN_EXT] = ~ext_rst_n_i;
  assign syn_in[`RBV_SYN_LOW] = supply_low_i;
  assign syn_in[`RBV_SYN_MON] = vdd_mon_trip_i;
  assign syn_in[`RBV_SYN_CMP] = cmp_out_i;
  assign syn_in[`RBV_SYN_MCD] = mcd_fault_i;

  rbv_sync #(
    .WIDTH   (`RBV_SYN_W),
    .RST_VAL (`RBV_SYN_RST)
  ) u_sync (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .async_i   (syn_in),
    .sync_o    (syn)
  );

  reg [2:0]        state_r;
  reg [2:0]        state_nxt;
  reg [HOLD_W-1:0] hold_cnt_r;
  reg [WDT_W-1:0]  wdt_cnt_r;
  reg              wdt_en_r;
  reg              wdt_lock_r;
  reg              wdt_ovf;
  reg [7:0]        req_vec;
  wire             req_any;

  always @* begin
    wdt_ovf = wdt_en_r && (wdt_cnt_r == WDT_LAST32[WDT_W-1:0]);
  end

  // Reset request vector, one bit per cause.
  always @* begin
    req_vec = 8'h00;
    req_vec[`RBV_CAUSE_EXT]    = syn[`RBV_SYN_EXT];
    req_vec[`RBV_CAUSE_SUPPLY] = syn[`RBV_SYN_LOW] |
                                 (vdd_mon_en_i & syn[`RBV_SYN_MON]);
    req_vec[`RBV_CAUSE_CMP]    = cmp_rst_en_i & syn[`RBV_SYN_CMP];
    req_vec[`RBV_CAUSE_SW]     = sw_rst_req_i;
    req_vec[`RBV_CAUSE_WDT]    = (state_r == ST_RUN) & wdt_ovf;
    req_vec[`RBV_CAUSE_MCD]    = mcd_en_i & syn[`RBV_SYN_MCD];
    req_vec[`RBV_CAUSE_FLASH]  = flash_err_i;
  end

  assign req_any = |req_vec;

  // Sequencer: any request drops straight back to the hold state.
  always @* begin
    state_nxt = state_r;
    if (req_any) begin
      state_nxt = ST_HOLD;
    end else begin
      case (state_r)
        ST_HOLD: begin
          state_nxt = ST_STRETCH;
        end
        ST_STRETCH: begin
          if (hold_cnt_r == HOLD_LAST32[HOLD_W-1:0]) begin
            state_nxt = ST_SIG_RD;
          end
        end
        ST_SIG_RD: begin
          if (flash_rd_valid_i) begin
            state_nxt = ST_VECTOR;
          end
        end
        ST_VECTOR: begin
          state_nxt = ST_RUN;
        end
        ST_RUN: begin
          state_nxt = ST_RUN;
        end
        default: begin
          state_nxt = ST_HOLD;
        end
      endcase
    end
  end

  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r    <= ST_HOLD;
      hold_cnt_r <= {HOLD_W{1'b0}};
    end else begin
      state_r <= state_nxt;
      if (state_r == ST_STRETCH && !req_any) begin
        hold_cnt_r <= hold_cnt_r + {{(HOLD_W-1){1'b0}}, 1'b1};
      end else begin
        hold_cnt_r <= {HOLD_W{1'b0}};
      end
    end
  end

  // The core, its registers and the pins stay forced until the vector is
  // loaded; releasing earlier would let a fetch race the marker read.
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      core_hold_o <= 1'b1;
      fetch_en_o  <= 1'b0;
    end else begin
      core_hold_o <= (state_nxt != ST_RUN);
      fetch_en_o  <= (state_nxt == ST_RUN);
    end
  end

  // Marker read: one request, held until the flash answers.
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flash_rd_o   <= 1'b0;
      flash_addr_o <= 16'h0000;
    end else begin
      flash_rd_o   <= (state_nxt == ST_SIG_RD);
      flash_addr_o <= SIG_ADDR32[15:0];
    end
  end

  // Marker decision is taken once per boot and then frozen; an erased
  // page reads back as all ones and so counts as absent.
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      boot_present_o <= 1'b0;
    end else if (state_r == ST_SIG_RD && flash_rd_valid_i && !req_any) begin
      boot_present_o <= (flash_rd_data_i == `RBV_SIG_PRESENT);
    end
  end

  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pc_load_o   <= 1'b0;
      pc_vector_o <= `RBV_RESET_VECTOR;
    end else begin
      pc_load_o <= (state_r == ST_VECTOR) && !req_any;
      if (state_r == ST_VECTOR) begin
        if (boot_present_o) begin
          pc_vector_o <= BOOT_VEC32[15:0];
        end else begin
          pc_vector_o <= `RBV_RESET_VECTOR;
        end
      end
    end
  end

  // Cause record: a new reset from the running state replaces the record,
  // further causes during the same reset accumulate.
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_cause_o <= `RBV_CAUSE_RST;
    end else if (req_any) begin
      if (state_r == ST_RUN) begin
        rst_cause_o <= req_vec;
      end else begin
        rst_cause_o <= rst_cause_o | req_vec;
      end
    end
  end

  // Watchdog: re-armed at the longest interval by every reset.
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wdt_en_r   <= 1'b1;
      wdt_lock_r <= 1'b0;
      wdt_cnt_r  <= {WDT_W{1'b0}};
    end else if (state_r != ST_RUN) begin
      wdt_en_r   <= 1'b1;
      wdt_lock_r <= 1'b0;
      wdt_cnt_r  <= {WDT_W{1'b0}};
    end else begin
      if (wdt_lock_i) begin
        wdt_lock_r <= 1'b1;
      end
      if (wdt_disable_i && !wdt_lock_r && !wdt_lock_i) begin
        wdt_en_r <= 1'b0;
      end
      if (wdt_kick_i || !wdt_en_r || wdt_ovf) begin
        wdt_cnt_r <= {WDT_W{1'b0}};
      end else begin
        wdt_cnt_r <= wdt_cnt_r + {{(WDT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wdt_running_o <= 1'b1;
    end else begin
      wdt_running_o <= (state_nxt != ST_RUN) ||
                       (wdt_en_r && !(wdt_disable_i && !wdt_lock_r &&
                                      !wdt_lock_i));
    end
  end

endmodule // rbv_reset_boot

// ===== bench/rbv_reset_boot_chk.sv
// Checker for reset entry and boot vector choice.
`timescale 1ns/100ps
`include "rbv_map.vh"
module rbv_reset_boot_chk #(
  parameter integer LOCK_ADDR  = 65535,
  parameter integer PAGE_BYTES = 512
) (
  input wire        ref_clk_i,
  input wire        rst_n_i,
  input wire        sw_rst_req_i,
  input wire        flash_err_i,
  input wire        flash_rd_valid_i,
  input wire [7:0]  flash_rd_data_i,
  input wire        core_hold_o,
  input wire        fetch_en_o,
  input wire        pc_load_o,
  input wire [15:0] pc_vector_o,
  input wire        flash_rd_o,
  input wire [15:0] flash_addr_o,
  input wire        boot_present_o,
  input wire        wdt_running_o
);
  localparam [15:0] BOOT_VEC = (LOCK_ADDR / PAGE_BYTES) * PAGE_BYTES;
  localparam [15:0] MARK     = LOCK_ADDR - 1;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  chk_fetch_inverse: assert property (
    fetch_en_o == !core_hold_o) else $error("fetch enable not inverse");
  chk_sw_hold: assert property (
    sw_rst_req_i |=> core_hold_o) else $error("software reset missed");
  chk_flash_hold: assert property (
    flash_err_i |=> core_hold_o) else $error("flash error reset missed");
  chk_marker_addr: assert property (
    flash_rd_o |-> flash_addr_o == MARK) else $error("marker address");
  chk_marker_decide: assert property (
    flash_rd_o && flash_rd_valid_i |=> !flash_rd_o && boot_present_o ==
    ($past(flash_rd_data_i) == `RBV_SIG_PRESENT)) else $error("marker");
  chk_vec_choice: assert property (
    pc_load_o |-> pc_vector_o == (boot_present_o ? BOOT_VEC :
    `RBV_RESET_VECTOR)) else $error("wrong start vector");
  chk_release_load: assert property (
    $fell(core_hold_o) |-> pc_load_o ##1 !pc_load_o) else $error("load");
  chk_vec_stable: assert property (
    !core_hold_o && $past(!core_hold_o) |-> $stable(pc_vector_o))
    else $error("vector moved while running");
  chk_wdt_boot: assert property (
    $rose(fetch_en_o) |-> wdt_running_o) else $error("watchdog stopped");
endmodule // rbv_reset_boot_chk

bind rbv_reset_boot rbv_reset_boot_chk #(
  .LOCK_ADDR(LOCK_ADDR), .PAGE_BYTES(PAGE_BYTES)) u_chk (
  .ref_clk_i, .rst_n_i, .sw_rst_req_i, .flash_err_i, .flash_rd_valid_i,
  .flash_rd_data_i, .core_hold_o, .fetch_en_o, .pc_load_o, .pc_vector_o,
  .flash_rd_o, .flash_addr_o, .boot_present_o, .wdt_running_o);

// ===== bench/rbv_flash_model.sv
// Flash model that answers the boot marker read.
`timescale 1ns/100ps
module rbv_flash_model #(
  parameter [15:0] MARK_ADDR = 16'hFFFE
) (
  input  wire        clk_i,
  input  wire        rst_n_i,
  input  wire        rd_i,
  input  wire [15:0] addr_i,
  input  wire [7:0]  marker_i,
  input  wire [3:0]  dly_i,
  output reg         valid_o,
  output reg  [7:0]  data_o
);
  reg [3:0] cnt_r;
  // Data toggles between answers so a stale byte never looks valid.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r   <= 4'h0;
      valid_o <= 1'b0;
      data_o  <= 8'h00;
    end else begin
      valid_o <= 1'b0;
      data_o  <= ~data_o;
      if (rd_i && !valid_o && cnt_r >= dly_i) begin
        valid_o <= 1'b1;
        cnt_r   <= 4'h0;
        data_o  <= (addr_i == MARK_ADDR) ? marker_i : 8'hFF;
      end else if (rd_i && !valid_o) begin
        cnt_r <= cnt_r + 4'h1;
      end else begin
        cnt_r <= 4'h0;
      end
    end
  end
endmodule // rbv_flash_model

// ===== bench/rbv_reset_boot_tb_top.sv
// Testbench for reset gathering and boot vector choice.
`timescale 1ns/100ps
module rbv_reset_boot_tb_top;
  localparam integer LOCK = 65535;
  localparam integer PAGE = 512;
  localparam [15:0] BOOT_VEC = (LOCK / PAGE) * PAGE;
  reg ref_clk_i, rst_n_i, ext_rst_n_i, supply_low_i, vdd_mon_trip_i;
  reg vdd_mon_en_i, cmp_out_i, cmp_rst_en_i, mcd_fault_i, mcd_en_i;
  reg sw_rst_req_i, flash_err_i, wdt_kick_i, wdt_disable_i, wdt_lock_i;
  wire core_hold_o, fetch_en_o, pc_load_o, flash_rd_o, boot_present_o;
  wire wdt_running_o, flash_rd_valid_i;
  wire [7:0] flash_rd_data_i, rst_cause_o;
  wire [15:0] pc_vector_o, flash_addr_o;
  reg [7:0] marker;
  reg [3:0] dly, kc;
  reg kick_on;
  integer n_errors, n_tests, k;
  integer cb[0:6] = '{1, 4, 4, 2, 6, 3, 7};
  reg [7:0] mk[0:6] = '{8'hFF, 8'hA4, 8'hA5, 8'h5A, 8'h00, 8'hA5, 8'hB5};
  rbv_reset_boot #(.LOCK_ADDR(LOCK), .PAGE_BYTES(PAGE), .WDT_MAX_CYC(64),
    .RST_HOLD(4)) uut (.ref_clk_i, .rst_n_i, .ext_rst_n_i, .supply_low_i,
    .vdd_mon_trip_i, .vdd_mon_en_i, .cmp_out_i, .cmp_rst_en_i,
    .mcd_fault_i, .mcd_en_i, .sw_rst_req_i, .flash_err_i, .wdt_kick_i,
    .wdt_disable_i, .wdt_lock_i, .flash_rd_valid_i, .flash_rd_data_i,
    .core_hold_o, .fetch_en_o, .pc_load_o, .pc_vector_o, .flash_rd_o,
    .flash_addr_o, .boot_present_o, .rst_cause_o, .wdt_running_o);
  rbv_flash_model #(.MARK_ADDR(LOCK - 1)) fm (.clk_i(ref_clk_i), .rst_n_i,
    .rd_i(flash_rd_o), .addr_i(flash_addr_o), .marker_i(marker),
    .dly_i(dly), .valid_o(flash_rd_valid_i), .data_o(flash_rd_data_i));
  initial begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end
  // Periodic kicks keep the watchdog quiet outside its own scenario.
  always @(posedge ref_clk_i) begin
    kc <= kc + 4'h1;
    wdt_kick_i <= kick_on && (kc == 4'hF);
  end
  task stop_test;
    $display("errors %0d checks %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input string nm, input [15:0] e, input [15:0] g);
    n_tests = n_tests + 1;
    if (g !== e) begin
      n_errors = n_errors + 1;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task wait_sig(input integer w, input integer lim);
    integer i;
    reg hit;
    begin
      hit = 1'b0;
      for (i = 0; i < lim && !hit; i = i + 1) begin
        @(posedge ref_clk_i);
        #1;
        hit = w ? (pc_load_o === 1'b1) : (core_hold_o === 1'b1);
      end
      if (!hit) begin
        chk("wait", 16'h0001, 16'h0000);
        stop_test;
      end
    end
  endtask
  task boot_chk(input [7:0] m);
    wait_sig(1, 200);
    chk("vector", (m == 8'hA5) ? BOOT_VEC : 16'h0000, pc_vector_o);
    chk("present", m == 8'hA5, boot_present_o);
    chk("fetch", 16'h0001, fetch_en_o);
  endtask
  task set_req(input integer i, input v);
    @(posedge ref_clk_i);
    case (i)
      0: ext_rst_n_i <= !v;
      1: supply_low_i <= v;
      2: vdd_mon_trip_i <= v;
      3: cmp_out_i <= v;
      4: mcd_fault_i <= v;
      5: sw_rst_req_i <= v;
      default: flash_err_i <= v;
    endcase
  endtask
  task src_case(input integer i);
    @(posedge ref_clk_i);
    marker <= mk[i];
    dly <= i[0] ? 4'h6 : 4'h1;
    set_req(i, 1'b1);
    wait_sig(0, 8);
    chk("halt", 16'h0000, fetch_en_o);
    repeat (3) @(posedge ref_clk_i);
    set_req(i, 1'b0);
    boot_chk(mk[i]);
    chk("cause", 8'h01 << cb[i], rst_cause_o);
  endtask
  task gated_case;
    @(posedge ref_clk_i);
    {vdd_mon_en_i, cmp_rst_en_i, mcd_en_i} <= 3'h0;
    {vdd_mon_trip_i, cmp_out_i, mcd_fault_i} <= 3'h7;
    repeat (10) @(posedge ref_clk_i);
    #1 chk("gated", 16'h0000, core_hold_o);
    @(posedge ref_clk_i);
    {vdd_mon_trip_i, cmp_out_i, mcd_fault_i} <= 3'h0;
    repeat (4) @(posedge ref_clk_i);
    {vdd_mon_en_i, cmp_rst_en_i, mcd_en_i} <= 3'h7;
  endtask
  task wdt_case;
    @(posedge ref_clk_i);
    kick_on <= 1'b0;
    wdt_lock_i <= 1'b1;
    @(posedge ref_clk_i);
    wdt_lock_i <= 1'b0;
    wdt_disable_i <= 1'b1;
    @(posedge ref_clk_i);
    wdt_disable_i <= 1'b0;
    repeat (40) @(posedge ref_clk_i);
    #1 chk("early", 16'h0000, core_hold_o);
    wait_sig(0, 40);
    kick_on <= 1'b1;
    boot_chk(marker);
    chk("wdt cause", 16'h0020, rst_cause_o);
    chk("wdt run", 16'h0001, wdt_running_o);
  endtask
  initial begin
    n_errors = 0;
    n_tests = 0;
    kc = 4'h0;
    {rst_n_i, ext_rst_n_i, vdd_mon_en_i, cmp_rst_en_i, mcd_en_i} = 5'h0F;
    {supply_low_i, vdd_mon_trip_i, cmp_out_i, mcd_fault_i} = 4'h0;
    {sw_rst_req_i, flash_err_i, wdt_kick_i, wdt_disable_i} = 4'h0;
    wdt_lock_i = 1'b0;
    kick_on = 1'b1;
    marker = 8'hA5;
    dly = 4'h1;
    repeat (4) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    boot_chk(8'hA5);
    chk("por", 16'h0001, rst_cause_o[0]);
    for (k = 0; k < 7; k = k + 1) src_case(k);
    gated_case;
    wdt_case;
    stop_test;
  end
endmodule // rbv_reset_boot_tb_top
